// ### bench/spc_slave_model.sv
/*
 * Far-side slave device for master-mode tests: clock phase 0, MSB first.
 * Assumes sck, mosi settle on clk_sys edges; miso shown only while active.
 */
`default_nettype none

module spc_slave_model (
  // Clock and link
  input  wire logic       clk_sys,
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Control
  input  wire logic       active,
  input  wire logic       load,
  input  wire logic [7:0] loadByte,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] sh;
  logic       sckPrev;
  logic       lastBit;

  // ==========================================================
  // Shift on falling clock, sample on rising clock
  always_ff @(posedge clk_sys) begin
    sckPrev <= sck;
    if (load) begin
      sh <= loadByte;
    end else if (sckPrev && !sck) begin
      sh <= {sh[6:0], 1'b0};
    end
    if (!sckPrev && sck) begin
      got <= {got[6:0], mosi};
    end
    if (active) begin
      lastBit <= sh[7];
    end
  end

  // Released line shows the inverse of the last bit, never a stale copy
  assign miso = active ? sh[7] : ~lastBit;
endmodule

`default_nettype wire

// ### bench/test_spc_pin_mode_and_rate_core.sv
/*
 * Self-checking bench for spc_core: pin routing table, master transfers,
 * gate, fault and stop cases. Assumes the slave model on pin group A.
 */
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module test_spc_pin_mode_and_rate_core;
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;

  typedef struct packed {
    logic [7:0] c1;
    logic [7:0] c2;
    logic [3:0] oe;
  } spc_row_t;

  // Option words and expected enables {ss,sck,mosi,miso}
  localparam spc_row_t ROWS [7] = '{
    '{8'h12, 8'h10, 4'h0}, '{8'h50, 8'h00, 4'h6}, '{8'h52, 8'h10, 4'hE},
    '{8'h50, 8'h10, 4'h6}, '{8'h50, 8'h09, 4'h6}, '{8'h50, 8'h01, 4'h4},
    '{8'h40, 8'h00, 4'h0}};

  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] ctrlOne = 8'h00, ctrlTwo = 8'h00, rateCtrl = 8'h21, txData = 8'h00;
  logic       pinPosSelect = 1'b0, gateWrite = 1'b0, gateData = 1'b1, stopLight = 1'b0;
  logic       stopDeep = 1'b0, txWrite = 1'b0, rxRead = 1'b0, modfClear = 1'b0;
  logic       ssLow = 1'b0, mActive = 1'b0, mLoad = 1'b0, misoM, clockGateOn;
  logic [7:0] mByte = 8'h00, mGot, rxData, statusOut;
  spc_pins_t  pinInA, pinOutA, pinOeA, pinOutB, pinOeB, frozen;
  int         err_count = 0, check_count = 0;

  // Undriven lines: clock pulled low, select and mosi pulled high
  assign pinInA = {pinOeA.ss ? pinOutA.ss : ~ssLow,
                   pinOeA.sck ? pinOutA.sck : 1'b0,
                   pinOeA.mosi ? pinOutA.mosi : 1'b1,
                   pinOeA.miso ? pinOutA.miso : misoM};

  spc_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ctrlOne(ctrlOne), .ctrlTwo(ctrlTwo),
    .rateCtrl(rateCtrl), .pinPosSelect(pinPosSelect), .gateWrite(gateWrite),
    .gateData(gateData), .stopLight(stopLight), .stopDeep(stopDeep), .txWrite(txWrite),
    .txData(txData), .rxRead(rxRead), .modfClear(modfClear), .rxData(rxData),
    .statusOut(statusOut), .clockGateOn(clockGateOn), .pinInA(pinInA), .pinOutA(pinOutA),
    .pinOeA(pinOeA), .pinInB(4'hF), .pinOutB(pinOutB), .pinOeB(pinOeB));

  spc_slave_model i_far (.clk_sys(clk_sys), .sck(pinInA.sck), .mosi(pinInA.mosi),
    .miso(misoM), .active(mActive), .load(mLoad), .loadByte(mByte), .got(mGot));

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic waitSt(input int b, input logic v);
    int k;
    k = 0;
    // Step off the edge so a flag updated by it is seen settled
    @(negedge clk_sys);
    while (statusOut[b] !== v) begin
      k++;
      if (k > 40000) begin
        err_count++;
        summarize();
      end
      @(negedge clk_sys);
    end
  endtask

  task automatic wrTx(input logic [7:0] b);
    @(posedge clk_sys);
    txData <= b;
    txWrite <= 1'b1;
    @(posedge clk_sys);
    txWrite <= 1'b0;
  endtask

  task automatic rdRx();
    @(posedge clk_sys);
    rxRead <= 1'b1;
    @(posedge clk_sys);
    rxRead <= 1'b0;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic [7:0] rx, input int half);
    int k;
    @(posedge clk_sys);
    mByte <= rx;
    mLoad <= 1'b1;
    mActive <= 1'b1;
    @(posedge clk_sys);
    mLoad <= 1'b0;
    wrTx(tx);
    k = 0;
    while (pinInA.sck !== 1'b1 && k < 5000) begin
      k++;
      @(negedge clk_sys);
    end
    if (k >= 5000) begin
      err_count++;
      summarize();
    end
    k = 0;
    while (pinInA.sck === 1'b1 && k < 5000) begin
      k++;
      @(negedge clk_sys);
    end
    if (k >= 5000) begin
      err_count++;
      summarize();
    end
    `CHK(k, half)
    waitSt(ST_SPRF, 1'b1);
    `CHK(rxData, rx)
    `CHK(mGot, tx)
    rdRx();
    mActive <= 1'b0;
  endtask

  initial begin
    cyc(20);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    `CHK(statusOut, 8'h20)
    `CHK(clockGateOn, 1'b1)
    `CHK(pinOeA, 4'h0)
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      ctrlOne <= ROWS[i].c1;
      ctrlTwo <= ROWS[i].c2;
      cyc(4);
      @(negedge clk_sys);
      `CHK(pinOeA, ROWS[i].oe)
      `CHK(pinOeB, 4'h0)
    end
    // Prescale and rate boundaries, half period (p+1)*2^n
    @(posedge clk_sys);
    ctrlOne <= 8'h50;
    ctrlTwo <= 8'h00;
    xfer(8'hA5, 8'h3C, 6);
    rateCtrl <= 8'h03;
    xfer(8'h96, 8'hE1, 8);
    rateCtrl <= 8'h78;
    xfer(8'h0F, 8'hF0, 2048);
    rateCtrl <= 8'h21;
    // Second byte waits in the buffer behind a running transfer
    mActive <= 1'b1;
    wrTx(8'h11);
    waitSt(ST_SPTEF, 1'b1);
    wrTx(8'h22);
    @(negedge clk_sys);
    `CHK(statusOut[ST_SPTEF], 1'b0)
    waitSt(ST_SPRF, 1'b1);
    rdRx();
    waitSt(ST_SPRF, 1'b1);
    `CHK(mGot, 8'h22)
    rdRx();
    mActive <= 1'b0;
    // Second pin group
    pinPosSelect <= 1'b1;
    cyc(4);
    @(negedge clk_sys);
    `CHK(pinOeB, 4'h6)
    `CHK(pinOeA, 4'h0)
    @(posedge clk_sys);
    pinPosSelect <= 1'b0;
    // Gate off: writes ignored
    gateData <= 1'b0;
    gateWrite <= 1'b1;
    @(posedge clk_sys);
    gateWrite <= 1'b0;
    wrTx(8'h77);
    cyc(3);
    @(negedge clk_sys);
    `CHK(clockGateOn, 1'b0)
    `CHK(statusOut[ST_SPTEF], 1'b1)
    // Deep stop restores reset state, gate included
    @(posedge clk_sys);
    stopDeep <= 1'b1;
    cyc(3);
    @(negedge clk_sys);
    `CHK(clockGateOn, 1'b1)
    `CHK(statusOut, 8'h20)
    `CHK(pinOeA, 4'h0)
    @(posedge clk_sys);
    stopDeep <= 1'b0;
    // Mode fault input pulled low
    ctrlTwo <= 8'h10;
    ssLow <= 1'b1;
    wrTx(8'h33);
    waitSt(ST_MODF, 1'b1);
    @(posedge clk_sys);
    ssLow <= 1'b0;
    // Select release needs the synchroniser delay, else the fault sets again
    cyc(4);
    modfClear <= 1'b1;
    @(posedge clk_sys);
    modfClear <= 1'b0;
    cyc(2);
    @(negedge clk_sys);
    `CHK(statusOut[ST_MODF], 1'b0)
    // Held byte goes out once the fault clears; drain it first
    waitSt(ST_SPRF, 1'b1);
    rdRx();
    // Light stop mid-transfer freezes, then resumes
    ctrlTwo <= 8'h00;
    mActive <= 1'b1;
    wrTx(8'h5A);
    cyc(20);
    stopLight <= 1'b1;
    cyc(2);
    @(negedge clk_sys);
    frozen = pinOutA;
    cyc(10);
    @(negedge clk_sys);
    `CHK(pinOutA, frozen)
    @(posedge clk_sys);
    stopLight <= 1'b0;
    waitSt(ST_SPRF, 1'b1);
    `CHK(mGot, 8'h5A)
    summarize();
  end
endmodule

`default_nettype wire

// ### rtl/spc_core.sv
/*
 * Serial peripheral port core: master/slave shifting, full-duplex or
 * single-wire pin routing, select and mode-fault pin use, two pin groups.
 * Assumes control words are held by system logic on clk_sys; pins arrive
 * unsynchronised and are sent out as output/enable pairs per group.
 */
// Behaviour
// - Pin group select routes all four pins; zero (default) picks group A.
// - Clock gate is on after reset; clearing it freezes the module.
// - Master alone starts transfers; each transfer swaps both shift registers.
// - Written byte waits in transmit buffer, loaded into shifter at start.
// - Finished received byte is copied into the receive buffer.
// - Master drives clock pin and MOSI, takes input from MISO.
// - Slave takes clock from pin, drives MISO, takes input from MOSI.
// - Prescaler divides bus clock by one to eight.
// - Rate stage divides prescaler output by one up to 256.
// - Disabled port releases all four pins; only the select pin, as master mode-fault input, still acts.
// - Single-wire master uses MOSI as data line, direction from enable bit.
// - Single-wire slave uses MISO as data line, direction from enable bit.
// - Single-wire slave releases the MOSI pin.
// - Single-wire master releases the MISO pin.
// - Slave always treats select pin as active-low select input.
// - Master without mode fault releases the select pin.
// - Master with mode fault: select is fault input or automatic output.
// - Disabled in stop modes; deep stop returns the reset state.
// - Light stop holds all state but the rate generator count, which keeps running; a reset exit restores reset state.
// - Five 8-bit software registers: options, rate, status, data.
`default_nettype none

module spc_core #(
  parameter int PRE_W    = spc_pkg::PRE_W,
  parameter int RATE_MAX = spc_pkg::RATE_MAX
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Option and rate words
  input  wire logic [7:0]        ctrlOne,
  input  wire logic [7:0]        ctrlTwo,
  input  wire logic [7:0]        rateCtrl,
  input  wire logic              pinPosSelect,
  // Clock gate and stop control
  input  wire logic              gateWrite,
  input  wire logic              gateData,
  input  wire logic              stopLight,
  input  wire logic              stopDeep,
  // Data and status
  input  wire logic              txWrite,
  input  wire logic [7:0]        txData,
  input  wire logic              rxRead,
  input  wire logic              modfClear,
  output logic [7:0]             rxData,
  output logic [7:0]             statusOut,
  output logic                   clockGateOn,
  // Pin group A
  input  wire spc_pkg::spc_pins_t pinInA,
  output spc_pkg::spc_pins_t     pinOutA,
  output spc_pkg::spc_pins_t     pinOeA,
  // Pin group B
  input  wire spc_pkg::spc_pins_t pinInB,
  output spc_pkg::spc_pins_t     pinOutB,
  output spc_pkg::spc_pins_t     pinOeB
);
  import spc_pkg::*;

  if (PRE_W != 3 || RATE_MAX > 15) begin : g_chk
    $error("spc_core: prescale field is three bits, rate field four");
  end

  spc_core_t  s;
  spc_core_t  n;
  spc_pins_t  inSel;
  spc_pins_t  actOe;
  spc_drive_t d;
  logic       en;
  logic       mst;
  logic       bidir;
  logic       dIn;
  logic       sel;
  logic       modfHit;
  logic       halt;
  logic       live;
  logic       tick;

  assign halt = !s.gate || stopLight;
  assign live = !halt && !stopDeep;

  // ==========================================================
  // Bit-rate generator
  spc_rate_gen #(
    .PRE_W   (PRE_W),
    .RATE_MAX(RATE_MAX)
  ) u_rate (
    .clk_sys(clk_sys),
    .rst_n  (rst_n),
    .run    (s.fsm == ST_MXFER && en),
    .preSel (rateCtrl[RC_PRE_LSB +: PRE_W]),
    .rateSel(rateCtrl[RC_RATE_LSB +: 4]),
    .tick   (tick)
  );

  // ==========================================================
  // Next state
  always_comb begin
    n = s;
    n.sync1 = {pinInB, pinInA};
    n.sync2 = s.sync1;
    n.pos = pinPosSelect;
    inSel = s.pos ? s.sync2[1] : s.sync2[0];
    en = ctrlOne[C1_SPE];
    mst = ctrlOne[C1_MSTR];
    bidir = ctrlTwo[C2_SINGLE_WIRE_SELECT];
    if (mst) begin
      dIn = bidir ? inSel.mosi : inSel.miso;
    end else begin
      dIn = bidir ? inSel.miso : inSel.mosi;
    end
    sel = !inSel.ss;
    modfHit = mst && ctrlTwo[C2_MODE_FAULT_ENABLE] && !ctrlOne[C1_SELECT_OUTPUT_ENABLE] && !inSel.ss;
    n.sckPrev = inSel.sck;
    // Clears go first so a same-cycle set wins
    if (rxRead) begin
      n.rxFull = 1'b0;
    end
    if (modfClear) begin
      n.modf = 1'b0;
    end
    unique case (s.fsm)
      ST_IDLE: begin
        n.bitCnt = '0;
        n.sck = 1'b0;
        if (mst && s.txFull && !modfHit) begin
          n.fsm = ST_MXFER;
          n.shift = s.txBuf;
          n.txFull = 1'b0;
        end else if (!mst && sel) begin
          n.fsm = ST_SXFER;
          if (s.txFull) begin
            n.shift = s.txBuf;
            n.txFull = 1'b0;
          end
        end
      end
      ST_MXFER: begin
        if (modfHit || !mst) begin
          n.fsm = ST_IDLE;
        end else if (tick) begin
          n.bitCnt = s.bitCnt + 4'h1;
          if (!s.bitCnt[0]) begin
            n.sck = 1'b1;
            n.sample = dIn;
          end else begin
            n.sck = 1'b0;
            n.shift = {s.shift[6:0], s.sample};
            if (s.bitCnt == LAST_EDGE) begin
              n.fsm = ST_IDLE;
              n.rxBuf = {s.shift[6:0], s.sample};
              n.rxFull = 1'b1;
            end
          end
        end
      end
      ST_SXFER: begin
        // Losing select mid-byte drops the partial byte
        if (mst || !sel) begin
          n.fsm = ST_IDLE;
        end else if (inSel.sck && !s.sckPrev) begin
          n.sample = dIn;
          n.bitCnt = s.bitCnt + 4'h1;
        end else if (!inSel.sck && s.sckPrev) begin
          n.bitCnt = s.bitCnt + 4'h1;
          n.shift = {s.shift[6:0], s.sample};
          if (s.bitCnt == LAST_EDGE) begin
            n.rxBuf = {s.shift[6:0], s.sample};
            n.rxFull = 1'b1;
            if (s.txFull) begin
              n.shift = s.txBuf;
              n.txFull = 1'b0;
            end
          end
        end
      end
    endcase
    if (modfHit) begin
      n.modf = 1'b1;
    end
    if (txWrite && en) begin
      n.txBuf = txData;
      n.txFull = 1'b1;
    end
    if (!en) begin
      n.fsm = ST_IDLE;
      n.txFull = 1'b0;
      n.rxFull = 1'b0;
      n.shift = '0;
      n.bitCnt = '0;
      n.sck = 1'b0;
    end
    // Pin drive, released unless a mode claims the pin
    d = '0;
    if (en && mst) begin
      d.oe.sck = 1'b1;
      d.out.sck = n.sck;
      d.out.mosi = n.shift[7];
      d.oe.mosi = bidir ? ctrlTwo[C2_BIDIR_OUTPUT_ENABLE] : 1'b1;
      if (ctrlTwo[C2_MODE_FAULT_ENABLE] && ctrlOne[C1_SELECT_OUTPUT_ENABLE]) begin
        d.oe.ss = 1'b1;
        d.out.ss = n.fsm != ST_MXFER;
      end
    end else if (en && sel) begin
      d.out.miso = n.shift[7];
      d.oe.miso = bidir ? ctrlTwo[C2_BIDIR_OUTPUT_ENABLE] : 1'b1;
    end
    n.drvA = n.pos ? '0 : d;
    n.drvB = n.pos ? d : '0;
    n.status = '0;
    n.status[ST_SPRF] = n.rxFull;
    n.status[ST_SPTEF] = !n.txFull;
    n.status[ST_MODF] = n.modf;
    // Halted clock keeps everything, the gate bit lives outside
    if (halt) begin
      n = s;
    end
    if (gateWrite) begin
      n.gate = gateData;
    end
    if (stopDeep) begin
      n = CORE_RST;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= CORE_RST;
    end else begin
      s <= n;
    end
  end

  assign rxData = s.rxBuf;
  assign statusOut = s.status;
  assign clockGateOn = s.gate;
  assign pinOutA = s.drvA.out;
  assign pinOeA = s.drvA.oe;
  assign pinOutB = s.drvB.out;
  assign pinOeB = s.drvB.oe;
  assign actOe = s.pos ? s.drvB.oe : s.drvA.oe;

  // ==========================================================
  // Checks
  property p_pos;
    @(posedge clk_sys) disable iff (!rst_n)
      !s.pos |-> s.drvB.oe == '0;
  endproperty
  a_pos: assert property (p_pos) else $error("group B driven while A chosen");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n)
      halt && !stopDeep |=> $stable(s.shift) && $stable(s.fsm) && $stable(s.txBuf);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while halted");

  property p_release;
    @(posedge clk_sys) disable iff (!rst_n)
      live && !ctrlOne[C1_SPE] |=> pinOeA == '0 && pinOeB == '0;
  endproperty
  a_release: assert property (p_release) else $error("pin driven while disabled");

  property p_txhold;
    @(posedge clk_sys) disable iff (!rst_n)
      live && ctrlOne[C1_SPE] && txWrite |=> s.txFull && s.txBuf == $past(txData);
  endproperty
  a_txhold: assert property (p_txhold) else $error("written byte not held");

  property p_rxcopy;
    @(posedge clk_sys) disable iff (!rst_n)
      live && en && mst && !modfHit && s.fsm == ST_MXFER && tick && s.bitCnt == LAST_EDGE
      |=> s.rxFull && s.rxBuf == {$past(s.shift[6:0]), $past(s.sample)};
  endproperty
  a_rxcopy: assert property (p_rxcopy) else $error("received byte not copied");

  property p_master;
    @(posedge clk_sys) disable iff (!rst_n)
      live && en && mst && !bidir |=> actOe.sck && actOe.mosi && !actOe.miso;
  endproperty
  a_master: assert property (p_master) else $error("master pin routing wrong");

  property p_mbidir;
    @(posedge clk_sys) disable iff (!rst_n)
      live && en && mst && bidir
      |=> actOe.mosi == $past(ctrlTwo[C2_BIDIR_OUTPUT_ENABLE]) && !actOe.miso;
  endproperty
  a_mbidir: assert property (p_mbidir) else $error("master shared line wrong");

  property p_sbidir;
    @(posedge clk_sys) disable iff (!rst_n)
      live && en && !mst && bidir && sel
      |=> actOe.miso == $past(ctrlTwo[C2_BIDIR_OUTPUT_ENABLE]) && !actOe.mosi;
  endproperty
  a_sbidir: assert property (p_sbidir) else $error("slave shared line wrong");

  property p_unsel;
    @(posedge clk_sys) disable iff (!rst_n)
      live && en && !mst && !sel |=> actOe == '0;
  endproperty
  a_unsel: assert property (p_unsel) else $error("unselected slave drives");

  property p_ssrel;
    @(posedge clk_sys) disable iff (!rst_n)
      live && en && mst && !ctrlTwo[C2_MODE_FAULT_ENABLE] |=> !actOe.ss;
  endproperty
  a_ssrel: assert property (p_ssrel) else $error("select pin not released");

  property p_ssout;
    @(posedge clk_sys) disable iff (!rst_n)
      live && en && mst && ctrlTwo[C2_MODE_FAULT_ENABLE] && ctrlOne[C1_SELECT_OUTPUT_ENABLE] |=> actOe.ss;
  endproperty
  a_ssout: assert property (p_ssout) else $error("select output not driven");

  property p_deep;
    @(posedge clk_sys) disable iff (!rst_n)
      stopDeep |=> s == CORE_RST ##1 !$past(stopDeep) || s == CORE_RST;
  endproperty
  a_deep: assert property (p_deep) else $error("deep stop not in reset state");

endmodule

`default_nettype wire

// ### rtl/spc_rate_gen.sv
/*
 * Master bit-rate generator: prescaler then power-of-two divider.
 * Emits one tick per half bit period while run is high.
 * Assumes run, preSel and rateSel come from logic on clk_sys.
 */
`default_nettype none

module spc_rate_gen #(
  parameter int PRE_W    = 3,
  parameter int RATE_MAX = 8
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Control
  input  wire logic               run,
  input  wire logic [PRE_W-1:0]   preSel,
  input  wire logic [3:0]         rateSel,
  // Half-bit tick
  output logic                    tick
);
  import spc_pkg::*;

  if (PRE_W < 1 || RATE_MAX < 1 || RATE_MAX > 15) begin : g_chk
    $error("spc_rate_gen: unsupported divider widths");
  end

  typedef struct packed {
    logic [PRE_W-1:0]    pre;
    logic [RATE_MAX-1:0] cnt;
    logic                tick;
  } spc_rg_t;

  spc_rg_t             s;
  spc_rg_t             n;
  logic [3:0]          rs;
  logic [RATE_MAX-1:0] lim;

  // ==========================================================
  // Divider
  always_comb begin
    n = s;
    n.tick = 1'b0;
    rs = (rateSel > 4'(RATE_MAX)) ? 4'(RATE_MAX) : rateSel;
    lim = RATE_MAX'((32'd1 << rs) - 32'd1);
    if (!run) begin
      n = '0;
    end else if (s.pre == preSel) begin
      n.pre = '0;
      if (s.cnt == lim) begin
        n.cnt = '0;
        n.tick = 1'b1;
      end else begin
        n.cnt = s.cnt + RATE_MAX'(1);
      end
    end else begin
      n.pre = s.pre + PRE_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign tick = s.tick;

  // ==========================================================
  // Tick spacing check
  logic [15:0] gap;
  logic [15:0] span;

  assign span = 16'((32'(preSel) + 32'd1) << rs);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gap <= '0;
    end else begin
      // Start one below zero so the first tick after start sees the same count
      gap <= !run ? 16'hFFFF : (tick ? 16'h0000 : gap + 16'h0001);
    end
  end

  property p_rate;
    @(posedge clk_sys) disable iff (!rst_n)
      tick && $stable(preSel) && $stable(rateSel) |-> gap == span - 16'h0001;
  endproperty
  a_rate: assert property (p_rate) else $error("half-bit period wrong");

endmodule

`default_nettype wire

// ### shared/spc_pkg.sv
/*
 * Package for the serial peripheral pin-mode and bit-rate core:
 * control-word field positions, reset values, pin carriers, state types.
 * Assumes the control words are held by system logic and arrive as ports.
 */
`default_nettype none

package spc_pkg;

  // ==========================================================
  // Control word fields
  localparam int C1_SPE      = 6;
  localparam int C1_MSTR     = 4;
  localparam int C1_SELECT_OUTPUT_ENABLE     = 1;
  localparam int C2_MODE_FAULT_ENABLE   = 4;
  localparam int C2_BIDIR_OUTPUT_ENABLE  = 3;
  localparam int C2_SINGLE_WIRE_SELECT     = 0;
  localparam int RC_PRE_LSB  = 4;
  localparam int RC_RATE_LSB = 0;
  localparam int ST_SPRF     = 7;
  localparam int ST_SPTEF    = 5;
  localparam int ST_MODF     = 4;

  // ==========================================================
  // Reset values and counts
  localparam logic       GATE_RST  = 1'b1;
  localparam logic       POS_RST   = 1'b0;
  localparam logic [3:0] LAST_EDGE = 4'hF;
  localparam int         PRE_W     = 3;
  localparam int         RATE_MAX  = 8;

  // ==========================================================
  // Carriers and state
  typedef struct packed {
    logic ss;
    logic sck;
    logic mosi;
    logic miso;
  } spc_pins_t;

  typedef struct packed {
    spc_pins_t out;
    spc_pins_t oe;
  } spc_drive_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_MXFER = 3'h2,
    ST_SXFER = 3'h4
  } spc_fsm_t;

  typedef struct packed {
    spc_fsm_t        fsm;
    logic            gate;
    logic            pos;
    spc_pins_t [1:0] sync1;
    spc_pins_t [1:0] sync2;
    logic            sckPrev;
    logic            sck;
    logic            sample;
    logic [3:0]      bitCnt;
    logic [7:0]      shift;
    logic [7:0]      txBuf;
    logic            txFull;
    logic [7:0]      rxBuf;
    logic            rxFull;
    logic            modf;
    logic [7:0]      status;
    spc_drive_t      drvA;
    spc_drive_t      drvB;
  } spc_core_t;

  function automatic spc_core_t spc_core_rst();
    spc_core_t r;
    r = '0;
    r.fsm = ST_IDLE;
    r.gate = GATE_RST;
    r.pos = POS_RST;
    r.status[ST_SPTEF] = 1'b1;
    return r;
  endfunction

  localparam spc_core_t CORE_RST = spc_core_rst();

endpackage

`default_nettype wire
